// file: core/vc0_arb_defines.svh
`ifndef VC0_ARB_DEFINES_SVH
`define VC0_ARB_DEFINES_SVH

// register indices as printed; byte address is four times the index
`define IDX_PORT_CHANNEL_STATUS  12'h020E
`define IDX_RESOURCE_ZERO_CAP    12'h0210
`define IDX_RESOURCE_ZERO_CTL    12'h0214
`define IDX_RESOURCE_ZERO_STS    12'h0218
`define IDX_ARB_TABLE_BASE       12'h0240
`define ARB_TABLE_WORDS          4

// capability fields
`define CAP_MASK_LSB             0
`define CAP_REJECT_SNOOP_BIT     15
`define CAP_SLOTS_LSB            16
`define CAP_TABLE_OFF_LSB        24
`define CAP_MASK_RESET           8'h01
`define CAP_TABLE_OFF_RESET      8'h04

// control fields
`define CTL_MAP_LSB              0
`define CTL_LOAD_BIT             16
`define CTL_SEL_LSB              17
`define CTL_CHAN_ID_LSB          24
`define CTL_ENABLE_BIT           31
`define CTL_MAP_RESET            8'hFF
`define CTL_SEL_RESET            3'h0

// status fields
`define STS_LOAD_PENDING_BIT     16

// lowest scheme code that walks the table
`define SEL_FIRST_TABLE_SCHEME   3'h2

// time to latch a new table into the arbiter
`define LOAD_TIME_NS             80
`define CLK_PERIOD_NS            20
`define LOAD_CYCLES              ((`LOAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: core/vc0_arb_pkg.sv
package vc0_arb_pkg;

	typedef logic [3:0] port_id_t;

	// one arbitration decision
	typedef struct packed {
		logic     valid;
		port_id_t port;
	} grant_s;

	// apb request as seen by the slave
	typedef struct packed {
		logic        sel;
		logic        enable;
		logic        write;
		logic [11:0] addr;
		logic [31:0] wdata;
		logic [3:0]  strb;
	} apb_req_s;

endpackage

// file: core/vc0_port_arbitration_regs.sv
// Design decision made here: the APB register port.
`timescale 1ns/100ps
`include "vc0_arb_defines.svh"

// Notes on behaviour
// - port channel status word reads all zero, table status bit included
// - capability mask resets to one, bit zero means hardware fixed
// - reject snoop flag reads zero
// - max time slots field reads zero
// - table offset in 16-byte units, resets to four, writable only when unlocked
// - classes whose map bit is set go to channel zero; map resets all ones
// - map bit zero is read-only, bits one to seven writable
// - writing one to load bit copies table into the arbiter
// - load bit is write-one trigger, writing zero does nothing, reads zero
// - load takes effect only when the selected scheme uses the table
// - channel identifier hard-wired to zero
// - channel enable hard-wired to one
// - any table write sets pending; a finished load clears it
// - each phase holds a four-bit port; invalid ports are skipped without delay
module vc0_port_arbitration_regs
	import vc0_arb_pkg::*;
(
	// clock and reset
	input  wire logic         CLK,
	input  wire logic         RST_B,
	// apb slave
	input  wire logic         PSEL,
	input  wire logic         PENABLE,
	input  wire logic         PWRITE,
	input  wire logic [11:0]  PADDR,
	input  wire logic [31:0]  PWDATA,
	input  wire logic [3:0]   PSTRB,
	output logic [31:0]       PRDATA,
	output logic              PREADY,
	output logic              PSLVERR,
	// lockable fields writable while high
	input  wire logic         CFG_UNLOCK,
	// traffic routing and arbitration
	output logic [7:0]        CLASS_TO_VC0,
	input  wire logic [15:0]  PORT_VALID,
	input  wire logic         ARB_ADVANCE,
	output grant_s            GRANT
);

	localparam int unsigned PHASES = `ARB_TABLE_WORDS * 8;
	localparam logic [2:0]  LOAD_CNT = 3'(`LOAD_CYCLES);

	// ----------------------------------------
	// bus decode
	// ----------------------------------------

	apb_req_s    req;
	logic [9:0]  idx;
	logic        hit_sts, hit_cap, hit_ctl, hit_rsts, hit_tbl;
	logic [1:0]  tbl_word;
	logic        mapped;
	logic        wr_acc;
	logic [31:0] bmask;

	assign req = '{PSEL, PENABLE, PWRITE, PADDR, PWDATA, PSTRB};
	assign idx = req.addr[11:2];

	// port status is a 16-bit word: index 0x20E shares nothing with others
	always_comb begin
		hit_sts  = ({idx, 2'b00} == 12'(`IDX_PORT_CHANNEL_STATUS * 4));
		hit_cap  = ({idx, 2'b00} == 12'(`IDX_RESOURCE_ZERO_CAP * 4));
		hit_ctl  = ({idx, 2'b00} == 12'(`IDX_RESOURCE_ZERO_CTL * 4));
		hit_rsts = ({idx, 2'b00} == 12'(`IDX_RESOURCE_ZERO_STS * 4));
		hit_tbl  = ({idx[9:2], 4'h0} == 12'(`IDX_ARB_TABLE_BASE * 4));
		tbl_word = idx[1:0];
		mapped   = hit_sts | hit_cap | hit_ctl | hit_rsts | hit_tbl;
	end

	// writes land only at the access edge, one per transfer
	assign wr_acc = req.sel & req.enable & req.write;
	assign bmask  = {{8{req.strb[3]}}, {8{req.strb[2]}}, {8{req.strb[1]}}, {8{req.strb[0]}}};

	// ----------------------------------------
	// capability register
	// ----------------------------------------

	logic [7:0] cap_mask_q;
	logic [7:0] tbl_off_q;

	// lockable fields; the lock keeps firmware defaults safe from drivers
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			cap_mask_q <= `CAP_MASK_RESET;
			tbl_off_q  <= `CAP_TABLE_OFF_RESET;
		end else if (wr_acc && hit_cap && CFG_UNLOCK) begin
			if (req.strb[0]) begin
				cap_mask_q <= req.wdata[`CAP_MASK_LSB +: 8];
			end
			if (req.strb[3]) begin
				tbl_off_q <= req.wdata[`CAP_TABLE_OFF_LSB +: 8];
			end
		end
	end

	// ----------------------------------------
	// control register
	// ----------------------------------------

	logic [7:0] map_q;
	logic [2:0] sel_q;
	logic       uses_table;

	// bit zero of the map never changes so class zero always reaches vc0
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			map_q <= `CTL_MAP_RESET;
			sel_q <= `CTL_SEL_RESET;
		end else if (wr_acc && hit_ctl) begin
			if (req.strb[0]) begin
				map_q <= {req.wdata[7:1], 1'b1};
			end
			if (req.strb[2]) begin
				sel_q <= req.wdata[`CTL_SEL_LSB +: 3];
			end
		end
	end

	assign CLASS_TO_VC0 = map_q;
	assign uses_table   = (sel_q >= `SEL_FIRST_TABLE_SCHEME);

	// ----------------------------------------
	// arbitration table and load sequence
	// ----------------------------------------

	logic [31:0] tbl_q    [`ARB_TABLE_WORDS];
	logic [31:0] active_q [`ARB_TABLE_WORDS];
	logic        tbl_wr;
	logic        load_req;
	logic        load_busy_q;
	logic [2:0]  load_cnt_q;
	logic        load_done;
	logic        pending_q;

	assign tbl_wr = wr_acc & hit_tbl & (|req.strb);

	// load is a trigger, not stored; the scheme gates it
	assign load_req = wr_acc & hit_ctl & req.strb[2] & req.wdata[`CTL_LOAD_BIT]
		& uses_table;
	assign load_done = load_busy_q & (load_cnt_q == 3'd1);

	// software copy of the table, byte lanes honoured
	generate
		for (genvar w = 0; w < `ARB_TABLE_WORDS; w++) begin : g_tbl
			always_ff @(posedge CLK or negedge RST_B) begin
				if (!RST_B) begin
					tbl_q[w] <= 32'h0000_0000;
				end else if (tbl_wr && tbl_word == 2'(w)) begin
					tbl_q[w] <= (tbl_q[w] & ~bmask) | (req.wdata & bmask);
				end
			end

			// arbiter copy; taken at the end so late writes are included
			always_ff @(posedge CLK or negedge RST_B) begin
				if (!RST_B) begin
					active_q[w] <= 32'h0000_0000;
				end else if (load_done) begin
					active_q[w] <= tbl_q[w];
				end
			end
		end
	endgenerate

	// a new request restarts the latch time
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			load_busy_q <= 1'b0;
			load_cnt_q  <= 3'd0;
		end else if (load_req) begin
			load_busy_q <= 1'b1;
			load_cnt_q  <= LOAD_CNT;
		end else if (load_busy_q) begin
			load_busy_q <= !load_done;
			load_cnt_q  <= load_cnt_q - 3'd1;
		end
	end

	// a table write in the finishing cycle keeps pending set
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			pending_q <= 1'b0;
		end else if (tbl_wr) begin
			pending_q <= 1'b1;
		end else if (load_done) begin
			pending_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// phase walker
	// ----------------------------------------

	logic [4:0] ptr_q;
	logic [4:0] hit_ph;
	logic       found;
	port_id_t   hit_port;
	port_id_t   ph_port;
	logic [4:0] ph;

	// search from the pointer so invalid ports cost no cycle
	always_comb begin
		found    = 1'b0;
		hit_ph   = ptr_q;
		hit_port = 4'h0;
		ph       = 5'd0;
		ph_port  = 4'h0;
		for (int i = 0; i < PHASES; i++) begin
			ph      = ptr_q + 5'(i);
			ph_port = active_q[ph[4:3]][ph[2:0] * 4 +: 4];
			if (!found && PORT_VALID[ph_port]) begin
				found    = 1'b1;
				hit_ph   = ph;
				hit_port = ph_port;
			end
		end
	end

	// grants only while the chosen scheme walks the table
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ptr_q <= 5'd0;
			GRANT <= '0;
		end else if (ARB_ADVANCE) begin
			GRANT.valid <= found & uses_table;
			GRANT.port  <= hit_port;
			if (found && uses_table) begin
				ptr_q <= hit_ph + 5'd1;
			end
		end else begin
			GRANT.valid <= 1'b0;
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------

	logic [31:0] cap_rd, ctl_rd, rd_d, rd_q;
	logic        err_q;

	// fixed fields are constants so nothing can disturb them
	always_comb begin
		cap_rd = {tbl_off_q, 1'b0, 7'h00, 1'b0, 7'h00, cap_mask_q};
		ctl_rd = {1'b1, 4'h0, 3'h0, 4'h0, sel_q, 1'b0, 8'h00, map_q};
		rd_d   = 32'h0000_0000;
		if (hit_sts) begin
			rd_d = 32'h0000_0000;
		end else if (hit_cap) begin
			rd_d = cap_rd;
		end else if (hit_ctl) begin
			rd_d = ctl_rd;
		end else if (hit_rsts) begin
			rd_d[`STS_LOAD_PENDING_BIT] = pending_q;
		end else if (hit_tbl) begin
			rd_d = tbl_q[tbl_word];
		end
	end

	// data caught in the setup cycle, shown in the access cycle
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			rd_q  <= 32'h0000_0000;
			err_q <= 1'b0;
		end else if (req.sel && !req.enable) begin
			rd_q  <= req.write ? 32'h0000_0000 : rd_d;
			err_q <= !mapped;
		end
	end

	assign PRDATA  = rd_q;
	assign PREADY  = 1'b1;
	assign PSLVERR = req.sel & req.enable & err_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------

	sequence s_load_start;
		load_req;
	endsequence

	sequence s_load_end;
		load_done ##1 (!pending_q || $past(tbl_wr));
	endsequence

	a_status_reads_zero: assert property (@(posedge CLK) disable iff (!RST_B)
		(req.sel && !req.enable && !req.write && hit_sts) |=> rd_q == 32'h0000_0000)
		else $error("port status word not zero");

	a_cap_fixed_zero: assert property (@(posedge CLK) disable iff (!RST_B)
		(req.sel && !req.enable && !req.write && hit_cap)
		|=> rd_q[23:8] == 16'h0000)
		else $error("snoop or time slot field not zero");

	a_offset_locked: assert property (@(posedge CLK) disable iff (!RST_B)
		!CFG_UNLOCK |=> $stable(tbl_off_q) && $stable(cap_mask_q))
		else $error("lockable field changed while locked");

	a_map_bit0_held: assert property (@(posedge CLK) disable iff (!RST_B)
		map_q[0] && CLASS_TO_VC0 == map_q)
		else $error("class zero left channel zero");

	a_ctl_read_fixed: assert property (@(posedge CLK) disable iff (!RST_B)
		(req.sel && !req.enable && !req.write && hit_ctl)
		|=> rd_q[31] && rd_q[26:24] == 3'h0 && !rd_q[16])
		else $error("control read shows wrong fixed bits");

	a_load_gated: assert property (@(posedge CLK) disable iff (!RST_B)
		(wr_acc && hit_ctl && !uses_table) |=> !load_busy_q || $past(load_busy_q))
		else $error("load started for a scheme without table");

	a_load_finishes: assert property (@(posedge CLK) disable iff (!RST_B)
		s_load_start ##1 (!load_req && !tbl_wr)[*4] |-> s_load_end)
		else $error("table load did not finish in time");

	a_load_copies: assert property (@(posedge CLK) disable iff (!RST_B)
		load_done |=> active_q[0] == $past(tbl_q[0]))
		else $error("arbiter copy differs from the table");

	a_pending_set: assert property (@(posedge CLK) disable iff (!RST_B)
		tbl_wr |=> pending_q)
		else $error("table write did not set pending");

	a_pending_cleared: assert property (@(posedge CLK) disable iff (!RST_B)
		(load_done && !tbl_wr) |=> !pending_q)
		else $error("pending still set after a finished load");

	a_grant_valid_port: assert property (@(posedge CLK) disable iff (!RST_B)
		(ARB_ADVANCE && found && uses_table) |=> GRANT.valid
		&& ($past(PORT_VALID) & (16'h0001 << GRANT.port)) != 16'h0000)
		else $error("granted an invalid port");

	a_grant_idle: assert property (@(posedge CLK) disable iff (!RST_B)
		!ARB_ADVANCE |=> !GRANT.valid)
		else $error("grant raised without an advance request");

	a_no_grant_unused: assert property (@(posedge CLK) disable iff (!RST_B)
		!uses_table |=> !GRANT.valid)
		else $error("grant given while the scheme ignores the table");

endmodule

// file: dv/vc0_port_arbitration_regs_tb.sv
`timescale 1ns/100ps
`include "vc0_arb_defines.svh"

module vc0_port_arbitration_regs_tb
	import vc0_arb_pkg::*;
;
	// ----------------------------------------------------------------
	// signals and register addresses
	// ----------------------------------------------------------------
	localparam logic [11:0] ADDR_PSTS = 12'(`IDX_PORT_CHANNEL_STATUS * 4);
	localparam logic [11:0] ADDR_CAP  = 12'(`IDX_RESOURCE_ZERO_CAP * 4);
	localparam logic [11:0] ADDR_CTL  = 12'(`IDX_RESOURCE_ZERO_CTL * 4);
	localparam logic [11:0] ADDR_RSTS = 12'(`IDX_RESOURCE_ZERO_STS * 4);
	localparam logic [11:0] ADDR_TBL  = 12'(`IDX_ARB_TABLE_BASE * 4);

	logic        clk;
	logic        rst_b;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cfg_unlock;
	logic [3:0]  pstrb;
	logic [7:0]  class_map;
	logic [15:0] port_valid;
	logic        arb_advance;
	grant_s      grant;
	logic [31:0] rdat;
	logic        rerr;
	int          n_fail;
	int          total_checks;

	vc0_port_arbitration_regs dut (
		.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .CFG_UNLOCK(cfg_unlock), .CLASS_TO_VC0(class_map),
		.PORT_VALID(port_valid), .ARB_ADVANCE(arb_advance), .GRANT(grant)
	);

	// ----------------------------------------------------------------
	// clock, reset and watchdog
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// whole run is about a hundred cycles; this is ample margin
	initial begin
		#200000;
		n_fail++;
		finish_test();
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	// apb cycle; request held until pready is seen high, answer taken at that edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		// no wait count assumed; only the watchdog ends a hung access
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rdat, exp, "register read");
	endtask

	// one advance pulse, grant checked in the cycle it stands
	task automatic adv(input logic [31:0] exp);
		@(posedge clk);
		arb_advance <= 1'b1;
		@(posedge clk);
		arb_advance <= 1'b0;
		#1;
		chk(32'(grant), exp, "grant");
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_values();
		rd(ADDR_PSTS, 32'h0000_0000);
		rd(ADDR_CAP, 32'h0400_0001);
		rd(ADDR_CTL, 32'h8000_00FF);
		rd(ADDR_RSTS, 32'h0000_0000);
		chk({24'h0, class_map}, 32'h0000_00FF, "map");
		apb(1'b0, 12'h3F0, 32'h0000_0000);
		chk({31'h0, rerr}, 32'h0000_0001, "unmapped error");
		chk(rdat, 32'h0000_0000, "unmapped data");
	endtask

	task automatic t_control_bits();
		// load with scheme 0 must not stick in the read value
		apb(1'b1, ADDR_CTL, 32'h7F01_FF00);
		rd(ADDR_CTL, 32'h8000_0001);
		chk({24'h0, class_map}, 32'h0000_0001, "map");
		apb(1'b1, ADDR_CTL, 32'h0000_00AA);
		// map register updates at the access edge; look one edge later
		@(posedge clk);
		chk({24'h0, class_map}, 32'h0000_00AB, "map");
		// lane two off: select and load bit keep out of the write
		pstrb <= 4'hB;
		apb(1'b1, ADDR_CTL, 32'h0005_0054);
		pstrb <= 4'hF;
		rd(ADDR_CTL, 32'h8000_0055);
	endtask

	task automatic t_lockable();
		apb(1'b1, ADDR_CAP, 32'hFFFF_FFFF);
		rd(ADDR_CAP, 32'h0400_0001);
		cfg_unlock <= 1'b1;
		apb(1'b1, ADDR_CAP, 32'hFFFF_FFFF);
		rd(ADDR_CAP, 32'hFF00_00FF);
		// advertise scheme two so selecting it later is legal
		apb(1'b1, ADDR_CAP, 32'h0400_0005);
		cfg_unlock <= 1'b0;
		rd(ADDR_CAP, 32'h0400_0005);
	endtask

	task automatic t_table_load();
		int n;
		port_valid <= 16'h0028;
		apb(1'b1, ADDR_TBL, 32'h0000_0053);
		rd(ADDR_RSTS, 32'h0001_0000);
		rd(ADDR_PSTS, 32'h0000_0000);
		adv(32'h0000_0000);
		// load under scheme 0 is ignored: pending stays
		apb(1'b1, ADDR_CTL, 32'h0001_00FE);
		repeat (8) @(posedge clk);
		rd(ADDR_RSTS, 32'h0001_0000);
		apb(1'b1, ADDR_CTL, 32'h0004_00FE);
		apb(1'b1, ADDR_CTL, 32'h0005_00FE);
		rd(ADDR_CTL, 32'h8004_00FF);
		for (n = 0; n < 20; n++) begin
			apb(1'b0, ADDR_RSTS, 32'h0000_0000);
			if (rdat === 32'h0000_0000)
				break;
		end
		chk(rdat, 32'h0000_0000, "pending after load");
		adv(32'h0000_0013);
		adv(32'h0000_0015);
		adv(32'h0000_0013);
		port_valid <= 16'h0008;
		adv(32'h0000_0013);
	endtask

	// ----------------------------------------------------------------
	// main sequence and verdict
	// ----------------------------------------------------------------
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		n_fail       = 0;
		total_checks = 0;
		rst_b        = 1'b0;
		psel         = 1'b0;
		penable      = 1'b0;
		pwrite       = 1'b0;
		paddr        = 12'h000;
		pwdata       = 32'h0000_0000;
		pstrb        = 4'hF;
		cfg_unlock   = 1'b0;
		port_valid   = 16'h0000;
		arb_advance  = 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		t_reset_values();
		t_control_bits();
		t_lockable();
		t_table_load();
		finish_test();
	end
endmodule
